// file: verilog/sgtt_regs.vh
`ifndef SGTT_REGS_VH
`define SGTT_REGS_VH

// power states
`define SGTT_ST_RUN        2'h0
`define SGTT_ST_GRANT      2'h1
`define SGTT_ST_SLEEP      2'h2
`define SGTT_ST_TRIP       2'h3
`define SGTT_ST_W          2

// clock gate vector positions
`define SGTT_CG_CORE       0
`define SGTT_CG_BUS        1
`define SGTT_CG_APIC       2
`define SGTT_CG_W          3

// sideband vector positions (excluded from lockstep compare)
`define SGTT_SB_TRIP       0
`define SGTT_SB_ERR        1
`define SGTT_SB_W          2

// synchroniser depth and input count
`define SGTT_SYNC_STAGES   3
`define SGTT_NUM_ASYNC     3
`define SGTT_IN_STOP       0
`define SGTT_IN_SLEEP      1
`define SGTT_IN_THERM      2

`endif

// file: verilog/sgtt_sync.v
`default_nettype none
`include "sgtt_regs.vh"

module sgtt_sync #(
    parameter [0:0] RESET_VAL = 1'b1
) (
    // clock and reset
    input  wire mclk_i,
    input  wire rst_n_i,
    // data
    input  wire async_i,
    input  wire bypass_i,
    output reg  sync_o
);

    reg [`SGTT_SYNC_STAGES-1:0] chain_q;

    // a change is taken once the second and third stages agree; in lockstep
    // mode the input is already synchronous and goes straight into sync_o, bypassing the chain
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chain_q <= {`SGTT_SYNC_STAGES{RESET_VAL}};
            sync_o  <= RESET_VAL;
        end else begin
            chain_q <= {chain_q[`SGTT_SYNC_STAGES-2:0], async_i};
            if (bypass_i) begin
                sync_o <= async_i;
            end else if (chain_q[1] == chain_q[2]) begin
                sync_o <= chain_q[2];
            end
        end
    end

endmodule

`default_nettype wire

// file: verilog/sgtt_ctrl.v
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`default_nettype none
`include "sgtt_regs.vh"

module sgtt_ctrl (
    // clock and reset
    input  wire                     mclk_i,
    input  wire                     rst_n_i,
    // system requests
    input  wire                     stop_clock_request_n_i,
    input  wire                     sleep_request_n_i,
    input  wire                     lockstep_compare_mode_i,
    input  wire                     power_good_in_i,
    // thermal sensor
    input  wire                     thermal_sensor_hot_i,
    // error sources
    input  wire                     internal_error_i,
    // lockstep compare
    input  wire [`SGTT_SB_W-1:0]    peer_sideband_i,
    input  wire                     peer_core_run_i,
    output reg                      lockstep_mismatch_o,
    // bus side
    output reg                      stop_grant_ack_o,
    output reg                      snoop_enable_o,
    output reg                      intr_enable_o,
    output reg                      bus_clk_run_o,
    // clock gates and execution
    output reg  [`SGTT_CG_W-1:0]    clk_gate_en_o,
    output reg                      pll_run_o,
    output reg                      exec_run_o,
    output reg  [`SGTT_ST_W-1:0]    state_o,
    // sideband
    output reg                      thermal_trip_out_n_o,
    output reg                      error_out_n_o
);

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    wire [`SGTT_NUM_ASYNC-1:0] raw_in;
    wire [`SGTT_NUM_ASYNC-1:0] syn_in;

    assign raw_in[`SGTT_IN_STOP]  = stop_clock_request_n_i;
    assign raw_in[`SGTT_IN_SLEEP] = sleep_request_n_i;
    assign raw_in[`SGTT_IN_THERM] = thermal_sensor_hot_i;

    wire mode_sync;
    // lockstep mode is a strap-like level, always synchronised
    sgtt_sync #(.RESET_VAL(1'b0)) u_mode_sync (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n_i),
        .async_i  (lockstep_compare_mode_i),
        .bypass_i (1'b0),
        .sync_o   (mode_sync)
    );

    // power-good stays asynchronous even in lockstep so it is never bypassed
    wire pgood_sync;
    sgtt_sync #(.RESET_VAL(1'b0)) u_pg_sync (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n_i),
        .async_i  (power_good_in_i),
        .bypass_i (1'b0),
        .sync_o   (pgood_sync)
    );

    genvar gi;
    generate
        for (gi = 0; gi < `SGTT_NUM_ASYNC; gi = gi + 1) begin : g_sync
            // in lockstep the system drives these on the bus clock
            // each chain resets to its pin's idle level, so reset release makes no edge
            sgtt_sync #(
                .RESET_VAL((gi == `SGTT_IN_THERM) ? 1'b0 : 1'b1)
            ) u_sync (
                .mclk_i   (mclk_i),
                .rst_n_i  (rst_n_i),
                .async_i  (raw_in[gi]),
                .bypass_i (mode_sync),
                .sync_o   (syn_in[gi])
            );
        end
    endgenerate

    wire stop_req  = ~syn_in[`SGTT_IN_STOP] & pgood_sync;
    wire sleep_req = ~syn_in[`SGTT_IN_SLEEP];
    // the sensor also waits for power-good, so a reading during power-up is not taken early
    wire therm_hot = syn_in[`SGTT_IN_THERM] & pgood_sync;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // trip and sleep stop every core clock; the pll is never gated
    function [`SGTT_CG_W-1:0] sgtt_gates;
        input [`SGTT_ST_W-1:0] st;
        begin
            case (st)
                `SGTT_ST_RUN:   sgtt_gates = {`SGTT_CG_W{1'b1}};
                `SGTT_ST_GRANT: sgtt_gates = {1'b1, 1'b1, 1'b0};
                default:        sgtt_gates = {`SGTT_CG_W{1'b0}};
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------------------
    reg [`SGTT_ST_W-1:0] state_q;
    reg [`SGTT_ST_W-1:0] state_d;
    reg                  trip_q;
    reg                  trip_d;

    always @* begin
        state_d = state_q;
        trip_d  = trip_q;
        // the trip latch has no way out but reset; a cooled sensor is ignored
        if (trip_q) begin
            state_d = `SGTT_ST_TRIP;
        end else if (therm_hot) begin
            trip_d  = 1'b1;
            state_d = `SGTT_ST_TRIP;
        end else begin
            case (state_q)
                `SGTT_ST_RUN: begin
                    if (stop_req) begin
                        state_d = `SGTT_ST_GRANT;
                    end
                end
                `SGTT_ST_GRANT: begin
                    if (!stop_req) begin
                        state_d = `SGTT_ST_RUN;
                    end else if (sleep_req) begin
                        state_d = `SGTT_ST_SLEEP;
                    end
                end
                `SGTT_ST_SLEEP: begin
                    // only the sleep request is looked at here; stop-clock
                    // release must wait for sleep release first
                    if (!sleep_req) begin
                        state_d = `SGTT_ST_GRANT;
                    end
                end
                default: state_d = `SGTT_ST_RUN;
            endcase
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= `SGTT_ST_RUN;
            trip_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            trip_q  <= trip_d;
        end
    end

    // ------------------------------------------------------------------------
    // lockstep compare
    // ------------------------------------------------------------------------
    // only the run flag is compared; trip and error pins may legitimately
    // differ between peers, so their positions are masked off
    wire [`SGTT_SB_W-1:0] my_sideband = {~internal_error_i, ~trip_d};
    wire [`SGTT_SB_W:0]   own_cmp     = {my_sideband, (state_d == `SGTT_ST_RUN)};
    wire [`SGTT_SB_W:0]   peer_cmp    = {peer_sideband_i, peer_core_run_i};
    wire [`SGTT_SB_W:0]   cmp_mask    = {{`SGTT_SB_W{1'b0}}, 1'b1};
    wire                  cmp_diff    = |((own_cmp ^ peer_cmp) & cmp_mask);

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    // snoop and interrupt service follow the next state, so they drop with the clocks
    wire entering_grant = (state_q == `SGTT_ST_RUN) && (state_d == `SGTT_ST_GRANT);
    wire alive          = (state_d == `SGTT_ST_RUN) || (state_d == `SGTT_ST_GRANT);

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stop_grant_ack_o     <= 1'b0;
            snoop_enable_o       <= 1'b1;
            intr_enable_o        <= 1'b1;
            bus_clk_run_o        <= 1'b1;
            clk_gate_en_o        <= {`SGTT_CG_W{1'b1}};
            pll_run_o            <= 1'b1;
            exec_run_o           <= 1'b1;
            state_o              <= `SGTT_ST_RUN;
            thermal_trip_out_n_o <= 1'b1;
            error_out_n_o        <= 1'b1;
            lockstep_mismatch_o  <= 1'b0;
        end else begin
            stop_grant_ack_o     <= entering_grant;
            snoop_enable_o       <= alive;
            intr_enable_o        <= alive;
            // external bus clock runs regardless of power state
            bus_clk_run_o        <= 1'b1;
            clk_gate_en_o        <= sgtt_gates(state_d);
            pll_run_o            <= 1'b1;
            exec_run_o           <= (state_d == `SGTT_ST_RUN);
            state_o              <= state_d;
            thermal_trip_out_n_o <= ~trip_d;
            error_out_n_o        <= ~internal_error_i;
            lockstep_mismatch_o  <= mode_sync && cmp_diff;
        end
    end

endmodule

`default_nettype wire

// file: test/sgtt_ctrl_monitor.sv
`default_nettype none
module sgtt_ctrl_monitor (
    // clock and reset
    input wire logic       mclk_i,
    input wire logic       rst_n_i,
    // watched outputs
    input wire logic [1:0] state_o,
    input wire logic       stop_grant_ack_o,
    input wire logic [2:0] clk_gate_en_o,
    input wire logic       snoop_enable_o,
    input wire logic       intr_enable_o,
    input wire logic       exec_run_o,
    input wire logic       bus_clk_run_o,
    input wire logic       pll_run_o,
    input wire logic       thermal_trip_out_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_ack_pulse: assert property (stop_grant_ack_o |-> state_o == 2'h1 ##1 !stop_grant_ack_o)
        else $error("ack not a single pulse in grant");
    a_ack_on_entry: assert property (state_o == 2'h1 && $past(state_o) == 2'h0 |-> stop_grant_ack_o)
        else $error("grant entered without ack");
    a_grant_gates: assert property (state_o == 2'h1 |-> clk_gate_en_o == 3'h6 && !exec_run_o)
        else $error("grant gating wrong");
    a_grant_snoop: assert property (state_o == 2'h1 |-> snoop_enable_o && intr_enable_o)
        else $error("grant stopped snoop or interrupts");
    a_run_clocks: assert property (state_o == 2'h0 |-> clk_gate_en_o == 3'h7 && exec_run_o)
        else $error("run without all clocks");
    a_bus_clock: assert property (bus_clk_run_o && pll_run_o)
        else $error("bus clock or pll stopped");
    a_trip_out: assert property ((state_o == 2'h3) == !thermal_trip_out_n_o)
        else $error("trip output and state disagree");
    a_trip_latch: assert property (state_o == 2'h3 |=> state_o == 2'h3 && !exec_run_o)
        else $error("trip released without reset");
    a_sleep_entry: assert property ($rose(state_o == 2'h2) |-> $past(state_o) == 2'h1)
        else $error("sleep entered outside grant");
    a_sleep_gates: assert property (state_o == 2'h2 |-> clk_gate_en_o == 3'h0 && !snoop_enable_o)
        else $error("sleep left clocks running");
    c_grant: cover property (state_o == 2'h1);
    c_sleep: cover property (state_o == 2'h2);
    c_trip: cover property (state_o == 2'h3);
endmodule
bind sgtt_ctrl sgtt_ctrl_monitor u_sgtt_ctrl_monitor (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .state_o(state_o), .stop_grant_ack_o(stop_grant_ack_o),
    .clk_gate_en_o(clk_gate_en_o), .snoop_enable_o(snoop_enable_o), .intr_enable_o(intr_enable_o),
    .exec_run_o(exec_run_o), .bus_clk_run_o(bus_clk_run_o), .pll_run_o(pll_run_o),
    .thermal_trip_out_n_o(thermal_trip_out_n_o)
);
`default_nettype wire

// file: test/sgtt_sys_model.sv
`default_nettype none
module sgtt_sys_model (
    input  wire logic       mclk_i,
    input  wire logic       lockstep_i,
    input  wire logic [1:0] cmd_i,
    output logic            stop_clock_request_n_o,
    output logic            sleep_request_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] async_q = 2'h3;
    logic [1:0] sync_q = 2'h3;
    // free mode moves the lines well away from any clock edge
    always @(cmd_i) async_q <= #1.3 ~cmd_i;
    always @(posedge mclk_i) sync_q <= ~cmd_i;
    assign stop_clock_request_n_o = lockstep_i ? sync_q[0] : async_q[0];
    assign sleep_request_n_o = lockstep_i ? sync_q[1] : async_q[1];
endmodule
`default_nettype wire

// file: test/tb_stop_grant_thermal_trip_ctrl.sv
`default_nettype none
module tb_stop_grant_thermal_trip_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       lock = 1'b0;
    logic       hot = 1'b0;
    logic       err = 1'b0;
    logic       peer_run = 1'b1;
    logic [1:0] peer_sb = 2'h0;
    logic [1:0] cmd = 2'h0;
    wire        stpn, slpn, mism, ack, snoop, intr, busclk, pll, exec, trip_n, err_n;
    wire  [2:0] gates;
    wire  [1:0] st;
    int         num_errors = 0;
    int         checks_done = 0;
    int         cyc = 0;

    always #2.5 mclk_i = ~mclk_i;

    sgtt_sys_model u_sgtt_sys_model (.mclk_i(mclk_i), .lockstep_i(lock), .cmd_i(cmd),
        .stop_clock_request_n_o(stpn), .sleep_request_n_o(slpn));
    sgtt_ctrl u_sgtt_ctrl (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .stop_clock_request_n_i(stpn),
        .sleep_request_n_i(slpn), .lockstep_compare_mode_i(lock), .power_good_in_i(1'b1),
        .thermal_sensor_hot_i(hot), .internal_error_i(err), .peer_sideband_i(peer_sb),
        .peer_core_run_i(peer_run), .lockstep_mismatch_o(mism), .stop_grant_ack_o(ack),
        .snoop_enable_o(snoop), .intr_enable_o(intr), .bus_clk_run_o(busclk), .clk_gate_en_o(gates),
        .pll_run_o(pll), .exec_run_o(exec), .state_o(st), .thermal_trip_out_n_o(trip_n),
        .error_out_n_o(err_n));

    task chk(input logic [3:0] got, input logic [3:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task cyc_n(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // bounded wait: synchroniser latency is a few edges, never twenty
    task wait_st(input logic [1:0] s);
        int k;
        k = 0;
        while (st !== s && k < 20) begin
            @(negedge mclk_i);
            k++;
        end
        chk({2'h0, st}, {2'h0, s}, "state");
    endtask
    task rst_pulse;
        rst_n_i = 1'b0;
        cyc_n(2);
        rst_n_i = 1'b1;
    endtask

    task t_sleep_ignored;
        cmd = 2'h2;
        cyc_n(10);
        chk({2'h0, st}, 4'h0, "sleep in run");
        cmd = 2'h0;
        cyc_n(6);
        // a request that covers a single clock edge must be filtered out
        cmd = 2'h1;
        cyc_n(1);
        cmd = 2'h0;
        repeat (8) begin
            cyc_n(1);
            chk({2'h0, st}, 4'h0, "glitch filtered");
        end
    endtask
    task t_grant;
        cmd = 2'h1;
        wait_st(2'h1);
        chk({3'h0, ack}, 4'h1, "ack");
        chk({1'h0, gates}, 4'h6, "grant gates");
        chk({snoop, intr, exec, busclk}, 4'hd, "grant flags");
        cyc_n(1);
        chk({3'h0, ack}, 4'h0, "ack width");
    endtask
    task t_sleep;
        cmd = 2'h3;
        wait_st(2'h2);
        chk({pll, gates}, 4'h8, "sleep clocks");
        cmd = 2'h2;
        cyc_n(10);
        chk({snoop, intr, st}, 4'h2, "sleep holds");
        cmd = 2'h0;
        wait_st(2'h1);
        chk({1'h0, gates}, 4'h6, "regrant gates");
        wait_st(2'h0);
        chk({exec, gates}, 4'hf, "run clocks");
    endtask
    task t_lockstep;
        lock = 1'b1;
        err = 1'b1;
        cyc_n(6);
        chk({3'h0, err_n}, 4'h0, "error out");
        cmd = 2'h1;
        wait_st(2'h1);
        cmd = 2'h0;
        wait_st(2'h0);
        peer_sb = 2'h3;
        cyc_n(6);
        chk({3'h0, mism}, 4'h0, "sideband excluded");
        peer_run = 1'b0;
        cyc_n(4);
        chk({3'h0, mism}, 4'h1, "run mismatch");
        peer_run = 1'b1;
        lock = 1'b0;
        err = 1'b0;
        cyc_n(6);
    endtask
    task t_trip;
        hot = 1'b1;
        wait_st(2'h3);
        chk({2'h0, trip_n, exec}, 4'h0, "trip");
        hot = 1'b0;
        cyc_n(10);
        chk({2'h0, st}, 4'h3, "trip latched");
        hot = 1'b1;
        rst_pulse();
        cyc_n(14);
        chk({st, trip_n, exec}, 4'hc, "still hot");
        hot = 1'b0;
        rst_pulse();
        cyc_n(14);
        chk({st, trip_n, exec}, 4'h3, "cooled");
    endtask

    task final_report;
        if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            final_report();
        end
    end

    initial begin
        cyc_n(8);
        rst_n_i = 1'b1;
        cyc_n(8);
        t_sleep_ignored();
        t_grant();
        t_sleep();
        t_lockstep();
        t_trip();
        final_report();
    end
endmodule
`default_nettype wire
